/* logic/supervisor_pkg.sv */
package supervisor_pkg;

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned TICK_NS          = 1_000;
    localparam int unsigned TICK_DIV         = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // interval figures in their own units
    // ------------------------------------------------------------
    localparam int unsigned RESET_TIMEOUT_MS = 200;
    localparam int unsigned WATCHDOG_MS      = 1_600;
    localparam int unsigned GLITCH_REJECT_NS = 100;
    localparam int unsigned MR_MIN_WIDTH_US  = 5;

    // interval counts in prescaled ticks; glitch window in clock cycles
    localparam int unsigned RESET_TICKS      = RESET_TIMEOUT_MS * 1_000_000 / TICK_NS;
    localparam int unsigned WATCHDOG_TICKS   = WATCHDOG_MS * 1_000_000 / TICK_NS;
    // debounce: longer than the glitch window, shorter than the guaranteed width
    localparam int unsigned DEBOUNCE_TICKS   = (MR_MIN_WIDTH_US * 1_000 / TICK_NS) - 2;
    localparam int unsigned GLITCH_CYCLES    = (GLITCH_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned TIMER_W          = 24;
    localparam int unsigned DIV_W            = 16;
    localparam int unsigned DEB_W            = 8;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b10
    } seq_state_t;

endpackage

/* logic/supply_supervisor.sv */
`timescale 1ns/1ns
// Overview of operation
// - reset outputs asserted whenever the supply-low indication is active.
// - after supply returns, reset held for the 200 ms timeout.
// - two open-drain reset outputs, one active high, one active low.
// - no watchdog input transition within 1.6 s asserts reset.
// - watchdog input is build-time choice: serial data line or kick pin.
// - any edge on the watchdog input restarts the watchdog period.
// - manual reset low asserts reset, held for full timeout after release.
// - manual reset input is debounced against bounces and glitches.
// - unconnected manual reset reads high, treated as deasserted.
// - external low on the active-low reset pin starts a full reset.
// - write-protect low allows memory writes, high blocks all writes.
// - writes inhibited while supply is low, including power-up.
// - build option: only active-low reset and no write-protect input.
// - manual reset pulses up to 100 ns ignored; 5 us recognised.
module supply_supervisor #(
    parameter bit              WDOG_ON_SDA    = 1'b1,
    parameter bit              DUAL_RESET     = 1'b1,
    parameter int unsigned     TICK_DIV       = supervisor_pkg::TICK_DIV,
    parameter int unsigned     RESET_TICKS    = supervisor_pkg::RESET_TICKS,
    parameter int unsigned     WATCHDOG_TICKS = supervisor_pkg::WATCHDOG_TICKS,
    parameter int unsigned     DEBOUNCE_TICKS = supervisor_pkg::DEBOUNCE_TICKS
) (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    input  wire logic i_supply_low,
    input  wire logic i_manual_reset_in_n,
    input  wire logic i_reset_n_pin,
    input  wire logic i_sda_in,
    input  wire logic i_watchdog_kick_in,
    input  wire logic i_write_protect,
    output logic      o_reset_n_out,
    output logic      o_reset_n_oe,
    output logic      o_reset_hi_out,
    output logic      o_reset_hi_oe,
    output logic      o_write_enable
);

    localparam int unsigned TW = supervisor_pkg::TIMER_W;
    localparam int unsigned DW = supervisor_pkg::DIV_W;
    localparam int unsigned BW = supervisor_pkg::DEB_W;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    wire  [5:0] raw_in = {i_supply_low, i_manual_reset_in_n, i_reset_n_pin,
                          i_sda_in, i_watchdog_kick_in, i_write_protect};

    // manual reset and reset pin idle at their pulled levels
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sync1_ff <= 6'h38;
            sync2_ff <= 6'h38;
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
        end
    end

    wire supply_low_s = sync2_ff[5];
    wire mr_n_s       = sync2_ff[4];
    wire rst_pin_n_s  = sync2_ff[3];
    wire wd_src_s     = WDOG_ON_SDA ? sync2_ff[2] : sync2_ff[1];
    wire wp_s         = sync2_ff[0];

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    logic [DW-1:0] div_ff;
    logic          tick_ff;
    wire           div_end = (div_ff == DW'(TICK_DIV - 1));
    wire [DW-1:0]  nxt_div = div_end ? '0 : div_ff + 1'b1;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            div_ff  <= nxt_div;
            tick_ff <= div_end;
        end
    end

    // ------------------------------------------------------------
    // manual reset glitch filter and debounce
    // ------------------------------------------------------------
    localparam int unsigned GC = supervisor_pkg::GLITCH_CYCLES;
    logic [BW-1:0] glitch_ff;
    logic          mr_filt_ff;
    logic [BW-1:0] deb_ff;
    logic          mr_active_ff;

    wire           mr_low_raw  = ~mr_n_s;
    wire           glitch_done = (glitch_ff == BW'(GC));
    wire [BW-1:0]  nxt_glitch  = mr_low_raw ? (glitch_done ? glitch_ff : glitch_ff + 1'b1) : '0;
    wire           nxt_mr_filt = mr_low_raw & glitch_done;

    // level must stay stable for the debounce count before being accepted
    wire           deb_diff   = (mr_filt_ff != mr_active_ff);
    wire           deb_done   = (deb_ff == BW'(DEBOUNCE_TICKS));
    wire [BW-1:0]  nxt_deb    = !deb_diff ? '0 : (tick_ff ? deb_ff + 1'b1 : deb_ff);
    wire           nxt_mr_act = (deb_diff && deb_done) ? mr_filt_ff : mr_active_ff;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            glitch_ff    <= '0;
            mr_filt_ff   <= 1'b0;
            deb_ff       <= '0;
            mr_active_ff <= 1'b0;
        end else begin
            glitch_ff    <= nxt_glitch;
            mr_filt_ff   <= nxt_mr_filt;
            deb_ff       <= deb_done && deb_diff ? '0 : nxt_deb;
            mr_active_ff <= nxt_mr_act;
        end
    end

    // external pull on the active-low pin, ignored while we drive it ourselves
    // and for the two synchroniser cycles after our own release
    logic       ext_pull_ff;
    logic [1:0] own_drive_ff;
    wire        own_mask     = o_reset_n_oe | own_drive_ff[0] | own_drive_ff[1];
    wire        nxt_ext_pull = ~rst_pin_n_s & ~own_mask;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ext_pull_ff  <= 1'b0;
            own_drive_ff <= 2'h3;
        end else begin
            ext_pull_ff  <= nxt_ext_pull;
            own_drive_ff <= {own_drive_ff[0], o_reset_n_oe};
        end
    end

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    logic          wd_prev_ff;
    logic [TW-1:0] wd_cnt_ff;
    logic          wd_fire_ff;
    logic          rst_asserted_ff;

    wire           wd_edge    = (wd_src_s != wd_prev_ff);
    wire           wd_expire  = tick_ff && (wd_cnt_ff == TW'(WATCHDOG_TICKS - 1));
    wire [TW-1:0]  nxt_wd_cnt = (rst_asserted_ff || wd_edge || wd_expire) ? '0
                              : (tick_ff ? wd_cnt_ff + 1'b1 : wd_cnt_ff);
    wire           nxt_wd_fire = ~rst_asserted_ff & ~wd_edge & wd_expire;

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wd_prev_ff <= 1'b0;
            wd_cnt_ff  <= '0;
            wd_fire_ff <= 1'b0;
        end else begin
            wd_prev_ff <= wd_src_s;
            wd_cnt_ff  <= nxt_wd_cnt;
            wd_fire_ff <= nxt_wd_fire;
        end
    end

    // ------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------
    supervisor_pkg::seq_state_t state_ff;
    supervisor_pkg::seq_state_t nxt_state;
    logic [TW-1:0]              hold_cnt_ff;

    // all reset sources; the watchdog fire is a one-cycle trigger
    wire          cause      = supply_low_s | mr_active_ff | ext_pull_ff | wd_fire_ff;
    wire          hold_done  = tick_ff && (hold_cnt_ff == TW'(RESET_TICKS - 1));
    wire [TW-1:0] nxt_hold   = (cause || state_ff != supervisor_pkg::ST_HOLD) ? '0
                             : (tick_ff ? hold_cnt_ff + 1'b1 : hold_cnt_ff);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            supervisor_pkg::ST_HOLD: begin
                if (!cause && hold_done) begin
                    nxt_state = supervisor_pkg::ST_RUN;
                end
            end
            supervisor_pkg::ST_RUN: begin
                if (cause) begin
                    nxt_state = supervisor_pkg::ST_HOLD;
                end
            end
            default: begin
                nxt_state = supervisor_pkg::ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff    <= supervisor_pkg::ST_HOLD;
            hold_cnt_ff <= '0;
        end else begin
            state_ff    <= nxt_state;
            hold_cnt_ff <= nxt_hold;
        end
    end

    wire nxt_rst_assert = (nxt_state == supervisor_pkg::ST_HOLD);

    // write gate: supply good (supply-low sync resets high for power-up), protect pin low
    wire  wp_term         = DUAL_RESET ? wp_s : 1'b0;
    wire  nxt_write_en    = ~supply_low_s & ~wp_term;

    // ------------------------------------------------------------
    // output drivers (open drain)
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_asserted_ff <= 1'b1;
            o_reset_n_out   <= 1'b0;
            o_reset_n_oe    <= 1'b1;
            o_reset_hi_out  <= 1'b0;
            o_reset_hi_oe   <= 1'b0;
            o_write_enable  <= 1'b0;
        end else begin
            rst_asserted_ff <= nxt_rst_assert;
            o_reset_n_out   <= 1'b0;
            o_reset_n_oe    <= nxt_rst_assert;
            o_reset_hi_out  <= 1'b0;
            o_reset_hi_oe   <= DUAL_RESET & ~nxt_rst_assert;
            o_write_enable  <= nxt_write_en;
        end
    end

endmodule

/* tb/supply_supervisor_monitor.sv */
`timescale 1ns/1ns
module supply_supervisor_monitor #(
    parameter bit          WDOG_ON_SDA    = 1'b1,
    parameter bit          DUAL_RESET     = 1'b1,
    parameter int unsigned TICK_DIV       = 2,
    parameter int unsigned RESET_TICKS    = 20,
    parameter int unsigned WATCHDOG_TICKS = 50,
    parameter int unsigned DEBOUNCE_TICKS = 2
) (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_supply_low,
    input wire logic i_manual_reset_in_n,
    input wire logic i_reset_n_pin,
    input wire logic i_sda_in,
    input wire logic i_watchdog_kick_in,
    input wire logic i_write_protect,
    input wire logic o_reset_n_out,
    input wire logic o_reset_n_oe,
    input wire logic o_reset_hi_out,
    input wire logic o_reset_hi_oe,
    input wire logic o_write_enable
);
    localparam int HOLD_MIN = (RESET_TICKS - 1) * TICK_DIV;
    localparam int HOLD_MAX = (RESET_TICKS + DEBOUNCE_TICKS + 2) * TICK_DIV + 16;
    localparam int WD_MAX   = (WATCHDOG_TICKS + 2) * TICK_DIV + 6;
    // ------------------------------------------------------------
    // cycles held with no cause, cycles since last kick edge
    // ------------------------------------------------------------
    logic [15:0] hold_ff;
    logic [15:0] wd_ff;
    logic        src_ff;
    wire         quiet = !i_supply_low && i_manual_reset_in_n;
    wire         src   = WDOG_ON_SDA ? i_sda_in : i_watchdog_kick_in;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hold_ff <= '0;
            wd_ff   <= '0;
            src_ff  <= 1'b0;
        end else begin
            hold_ff <= (o_reset_n_oe && quiet) ? hold_ff + 16'h1 : 16'h0;
            wd_ff   <= (o_reset_n_oe || src != src_ff) ? 16'h0 : wd_ff + 16'h1;
            src_ff  <= src;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    AST_SUPPLY_RESET: assert property (i_supply_low [*5] |-> o_reset_n_oe)
        else $error("no reset on low supply");
    AST_HOLD_MIN: assert property ($fell(o_reset_n_oe) |-> hold_ff >= HOLD_MIN)
        else $error("reset released early");
    AST_HOLD_MAX: assert property (hold_ff <= HOLD_MAX)
        else $error("reset held too long");
    AST_PAIR: assert property (o_reset_hi_oe == (DUAL_RESET && !o_reset_n_oe))
        else $error("reset outputs disagree");
    AST_OPEN_DRAIN: assert property (!o_reset_n_out && !o_reset_hi_out)
        else $error("open drain data high");
    AST_WDOG_FIRES: assert property (wd_ff <= WD_MAX)
        else $error("watchdog did not fire");
    AST_WP_BLOCK: assert property ((DUAL_RESET && i_write_protect) [*4] |-> !o_write_enable)
        else $error("write not blocked");
    AST_SUPPLY_WE: assert property (i_supply_low [*4] |-> !o_write_enable)
        else $error("write on low supply");
    AST_WE_GOOD: assert property ((!i_supply_low && !(DUAL_RESET && i_write_protect)) [*6] |-> o_write_enable)
        else $error("write not allowed");
    cover property ($rose(o_reset_n_oe) && quiet);
    cover property ($fell(o_reset_n_oe));
    cover property (o_write_enable ##1 !o_write_enable);
endmodule
bind supply_supervisor supply_supervisor_monitor #(.WDOG_ON_SDA(WDOG_ON_SDA), .DUAL_RESET(DUAL_RESET),
    .TICK_DIV(TICK_DIV), .RESET_TICKS(RESET_TICKS), .WATCHDOG_TICKS(WATCHDOG_TICKS),
    .DEBOUNCE_TICKS(DEBOUNCE_TICKS)) mon (.*);

/* tb/host_mcu_model.sv */
`timescale 1ns/1ns
module host_mcu_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n_oe,
    input  wire logic       i_reset_hi_oe,
    input  wire logic       i_ext_pull,
    input  wire logic       i_stall,
    input  wire logic [7:0] i_kick_gap,
    output logic            o_reset_n_wire,
    output logic            o_reset_hi_wire,
    output logic            o_sda
);
    // ------------------------------------------------------------
    // wires with pull-up, kicks on serial data unless hung
    // ------------------------------------------------------------
    logic [7:0] gap_ff = 8'h00;
    assign o_reset_n_wire  = !(i_reset_n_oe || i_ext_pull);
    assign o_reset_hi_wire = !i_reset_hi_oe;
    initial o_sda = 1'b1;
    always @(posedge i_clk) begin
        gap_ff <= gap_ff + 8'h01;
        if (!i_stall && gap_ff >= i_kick_gap) begin
            gap_ff <= 8'h00;
            o_sda  <= !o_sda;
        end
    end
endmodule

/* tb/supply_supervisor_tb.sv */
`timescale 1ns/1ns
module supply_supervisor_tb;
    localparam int DIV = 2;
    localparam int T_HOLD = 20 * DIV;
    localparam int T_WD = 50 * DIV;
    logic        clk = 1'b0, sys_rst = 1'b1, supply_low = 1'b0, mr_n = 1'b1, kick_pin = 1'b0;
    logic        wp = 1'b0, ext_pull = 1'b0, stall = 1'b0;
    logic [7:0]  gap = 8'h10;
    logic [31:0] seed = 32'h0DDCD452, r;
    logic        n_oe, hi_oe, we, n_wire, hi_wire, sda;
    int          err_total = 0, total_checks = 0;
    always #5 clk = !clk;
    supply_supervisor #(.WDOG_ON_SDA(1'b1), .DUAL_RESET(1'b1), .TICK_DIV(DIV), .RESET_TICKS(20),
        .WATCHDOG_TICKS(50), .DEBOUNCE_TICKS(2)) uut (.i_clk(clk), .i_sys_rst(sys_rst),
        .i_supply_low(supply_low), .i_manual_reset_in_n(mr_n), .i_reset_n_pin(n_wire), .i_sda_in(sda),
        .i_watchdog_kick_in(kick_pin), .i_write_protect(wp), .o_reset_n_out(), .o_reset_n_oe(n_oe),
        .o_reset_hi_out(), .o_reset_hi_oe(hi_oe), .o_write_enable(we));
    host_mcu_model host (.i_clk(clk), .i_reset_n_oe(n_oe), .i_reset_hi_oe(hi_oe), .i_ext_pull(ext_pull),
        .i_stall(stall), .i_kick_gap(gap), .o_reset_n_wire(n_wire), .o_reset_hi_wire(hi_wire), .o_sda(sda));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic exp_we(input logic low, input logic prot);
        return !low && !prot;
    endfunction
    task automatic chk(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
        end
    endtask
    task automatic oe_in(input string name, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (n_oe !== v && n <= hi) begin
            @(negedge clk);
            n++;
        end
        chk(name, 1'b1, n >= lo && n <= hi);
    endtask
    task automatic stay_off(input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(negedge clk);
            bad = bad | n_oe;
        end
        chk("no_reset", 1'b0, bad);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        finish_test();
    end
    initial begin
        @(negedge clk);
        chk("write_enable", 1'b0, we);
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        oe_in("power_up_hold", 1'b0, T_HOLD - 2, T_HOLD + 8);
        chk("reset_hi_wire", 1'b0, hi_wire);
        @(posedge clk) supply_low <= 1'b1;
        oe_in("low_supply", 1'b1, 0, 6);
        repeat (3 + rnd() % 20) @(negedge clk);
        chk("reset_hi_wire", 1'b1, hi_wire);
        chk("write_enable", exp_we(supply_low, wp), we);
        @(posedge clk) supply_low <= 1'b0;
        oe_in("brownout_hold", 1'b0, T_HOLD - 2, T_HOLD + 8);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            @(posedge clk) wp <= r[0];
            gap <= 8'(r[15:8] % 80 + 4);
            stay_off(40);
            chk("write_enable", exp_we(supply_low, wp), we);
        end
        @(posedge clk) stall <= 1'b1;
        fork
            oe_in("watchdog_fire", 1'b1, T_WD - int'(gap) - 8, T_WD + 10);
            repeat (T_WD) @(posedge clk) kick_pin <= !kick_pin;
        join
        oe_in("watchdog_hold", 1'b0, T_HOLD - 2, T_HOLD + 8);
        oe_in("watchdog_restart", 1'b1, T_WD - 4, T_WD + 10);
        @(posedge clk) stall <= 1'b0;
        oe_in("restart_hold", 1'b0, T_HOLD - 2, T_HOLD + 8);
        @(posedge clk) mr_n <= 1'b0;
        repeat (1 + rnd() % 6) @(posedge clk);
        mr_n <= 1'b1;
        stay_off(30);
        @(posedge clk) mr_n <= 1'b0;
        oe_in("manual_reset", 1'b1, 0, 40);
        repeat (50) @(posedge clk);
        mr_n <= 1'b1;
        oe_in("manual_hold", 1'b0, T_HOLD - 2, T_HOLD + 24);
        @(posedge clk) ext_pull <= 1'b1;
        oe_in("ext_pull", 1'b1, 0, 40);
        @(posedge clk) ext_pull <= 1'b0;
        oe_in("ext_hold", 1'b0, T_HOLD - 12, T_HOLD + 40);
        finish_test();
    end
endmodule
